// file: sfr_defines.svh
// constants for the serial flash read and address-mode block
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// ****************************************
// instruction codes
// ****************************************
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST_READ 8'h0B
`define SFR_OP_DUAL_OUTPUT_READ 8'h3B
`define SFR_OP_DUAL_IO_READ 8'hBB
`define SFR_OP_ENTER_WIDE 8'hB7
`define SFR_OP_EXIT_WIDE 8'hE9
`define SFR_OP_PARAM_TABLE_READ 8'h5A
`define SFR_OP_SIGNATURE_READ 8'hAB
`define SFR_OP_MAKER_DEVICE_ID_READ 8'h90

// ****************************************
// configuration view layout and reset values
// ****************************************
`define SFR_WIDE_FLAG_BIT 5
`define SFR_DUMMY_SEL_LSB 6
`define SFR_WIDE_FLAG_RESET 1'b0

// ****************************************
// phase lengths: command and address in bits, dummies in serial clock edges
// ****************************************
`define SFR_CMD_BITS 4'h8
`define SFR_NARROW_ADDR_BITS 6'h18
`define SFR_WIDE_ADDR_BITS 6'h20
`define SFR_DUMMY_STD_00 6'h08
`define SFR_DUMMY_STD_01 6'h06
`define SFR_DUMMY_STD_10 6'h08
`define SFR_DUMMY_STD_11 6'h0A
`define SFR_DUMMY_DIO_00 6'h04
`define SFR_DUMMY_DIO_01 6'h06
`define SFR_DUMMY_DIO_10 6'h08
`define SFR_DUMMY_DIO_11 6'h0A

`endif

// file: sfr_pkg.sv
// types shared by the serial flash read and address-mode block
package sfr_pkg;

  typedef enum logic [2:0] {
    SFR_ST_CMD,
    SFR_ST_ADDR,
    SFR_ST_DUMMY,
    SFR_ST_DATA,
    SFR_ST_HOLD,
    SFR_ST_IGNORE
  } sfr_state_type;

  typedef enum logic [1:0] {
    SFR_RD_SINGLE,
    SFR_RD_FAST,
    SFR_RD_DUAL_OUT,
    SFR_RD_DUAL_IO
  } sfr_read_kind_type;

endpackage

// file: sfr_link_if.sv
// synchronised link events passed from the pin front end to the sequencer
`timescale 1ns/1ps
interface sfr_link_if;
  logic cs_active;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic lane0;
  logic lane1;

  modport front (output cs_active, cs_rise, sclk_rise, sclk_fall, lane0, lane1);
  modport core (input cs_active, cs_rise, sclk_rise, sclk_fall, lane0, lane1);
endinterface

// file: sfr_link_sync.sv
// two-stage synchronisers and edge finders for the serial link pins
`timescale 1ns/1ps
module sfr_link_sync (
  input wire logic core_clk, // block clock
  input wire logic reset_n, // async reset, active low
  input wire logic cs_n_pin, // chip select pin, active low
  input wire logic sclk_pin, // serial clock pin
  input wire logic io_lane0_in, // lane 0 pin level
  input wire logic io_lane1_in, // lane 1 pin level
  sfr_link_if.front link // events toward the sequencer
);
  // ****************************************
  // synchroniser stages
  // ****************************************
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [1:0] last_reg;
  logic cs_n_sync;
  logic sclk_sync;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle levels: select high, clock low, so no false edge after reset
      meta_reg <= 4'hB;
      sync_reg <= 4'hB;
      last_reg <= 2'h2;
    end else begin
      meta_reg <= {cs_n_pin, sclk_pin, io_lane1_in, io_lane0_in};
      sync_reg <= meta_reg;
      last_reg <= sync_reg[3:2];
    end
  end

  assign cs_n_sync = sync_reg[3];
  assign sclk_sync = sync_reg[2];
  // ****************************************
  // link events: clock and select-rise edges one core cycle each, select and lanes as levels
  // ****************************************
  assign link.cs_active = !cs_n_sync;
  assign link.cs_rise = cs_n_sync && !last_reg[1];
  // clock edges only count inside a frame
  assign link.sclk_rise = sclk_sync && !last_reg[0] && !cs_n_sync;
  assign link.sclk_fall = !sclk_sync && last_reg[0] && !cs_n_sync;
  assign link.lane0 = sync_reg[0];
  assign link.lane1 = sync_reg[1];
endmodule

// file: sfr_flash_read.sv
// command sequencer for address-width mode and the read family
`timescale 1ns/1ps
`include "sfr_defines.svh"

// Behaviour
// - addresses are 24-bit after reset, 32-bit once wide mode is entered
// - enter-wide instruction sets the wide flag at bit 5
// - wide mode ends only by exit instruction, reset or power-off
// - in wide mode all instructions work normally; only address length changes
// - parameter, signature and id reads always keep a 24-bit address
// - exit-wide instruction clears bit 5 and restores 24-bit addresses
// - plain read: code, address, then data on lane 1, no dummies
// - address sampled on serial clock rise, data driven on fall
// - address steps by one per byte and wraps to zero past the top
// - narrow mode reaches high memory through the extended address byte
// - fast read: code, address, 8 default dummies, then one bit per clock
// - fast, dual-output and dual-io reads refused while busy
// - dual-output read: address on lane 0, data two bits per clock
// - dual-output read widens only the data phase
// - dual-io read: address, 4 default dummies and data on two lanes
// - dummy select picks 8/6/8/10 or, for dual-io, 4/6/8/10 cycles
module sfr_flash_read
  import sfr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic core_clk, // block clock, 200 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic cs_n_pin, // chip select pin, active low
  input wire logic sclk_pin, // serial clock pin
  input wire logic io_lane0_in, // lane 0 input level
  input wire logic io_lane1_in, // lane 1 input level
  output logic io_lane0_out, // lane 0 output level
  output logic io_lane0_oe, // lane 0 driven
  output logic io_lane1_out, // lane 1 output level
  output logic io_lane1_oe, // lane 1 driven
  input wire logic write_busy, // program, erase or status write running
  input wire logic [1:0] dummy_count_select, // dummy cycle code
  input wire logic [7:0] extended_address_byte, // top byte in narrow mode
  output logic wide_address_flag, // wide addressing active
  output logic [7:0] config_view, // flag and dummy code in register layout
  output logic read_rejected, // pulse: read refused while busy
  output logic [ADDR_W-1:0] mem_addr, // array byte address
  output logic mem_rd, // pulse: fetch byte at mem_addr
  input wire logic [7:0] mem_rdata // byte, valid the cycle after mem_rd
);
  // the address counter cannot serve widths outside the 24- to 32-bit range
  if (ADDR_W < 24 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 24 and 32");
  end

  localparam logic [ADDR_W-1:0] MEM_LAST = {ADDR_W{1'b1}};

  sfr_link_if link ();

  sfr_link_sync u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .io_lane0_in(io_lane0_in),
    .io_lane1_in(io_lane1_in),
    .link(link)
  );

  // ****************************************
  // state
  // ****************************************
  sfr_state_type state_reg;
  sfr_read_kind_type kind_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] cmd_sh_reg;
  logic [5:0] cnt_reg;
  logic [5:0] dummy_reg;
  logic [31:0] addr_sh_reg;
  logic [7:0] byte_reg;
  logic [7:0] out_sh_reg;
  logic [3:0] left_reg;
  logic fetch_wait_reg;
  logic wide_reg;

  // ****************************************
  // decode
  // ****************************************
  wire [7:0] opcode = {cmd_sh_reg[6:0], link.lane0};
  wire last_cmd_bit = bit_cnt_reg == 4'(`SFR_CMD_BITS - 4'h1);
  wire is_read = opcode == `SFR_OP_READ;
  wire is_fast = opcode == `SFR_OP_FAST_READ;
  wire is_dout = opcode == `SFR_OP_DUAL_OUTPUT_READ;
  wire is_dio = opcode == `SFR_OP_DUAL_IO_READ;
  wire is_mode = opcode == `SFR_OP_ENTER_WIDE || opcode == `SFR_OP_EXIT_WIDE;
  wire is_any_read = is_read || is_fast || is_dout || is_dio;
  wire refuse = write_busy && (is_fast || is_dout || is_dio);
  wire [5:0] addr_bits = wide_reg ? `SFR_WIDE_ADDR_BITS : `SFR_NARROW_ADDR_BITS;
  wire [5:0] dummy_std = dummy_count_select == 2'h0 ? `SFR_DUMMY_STD_00 :
                         dummy_count_select == 2'h1 ? `SFR_DUMMY_STD_01 :
                         dummy_count_select == 2'h2 ? `SFR_DUMMY_STD_10 :
                         `SFR_DUMMY_STD_11;
  wire [5:0] dummy_dio = dummy_count_select == 2'h0 ? `SFR_DUMMY_DIO_00 :
                         dummy_count_select == 2'h1 ? `SFR_DUMMY_DIO_01 :
                         dummy_count_select == 2'h2 ? `SFR_DUMMY_DIO_10 :
                         `SFR_DUMMY_DIO_11;
  // dual-io carries two bits per edge in address and data phases
  wire dual_in = kind_reg == SFR_RD_DUAL_IO;
  wire dual_out = kind_reg == SFR_RD_DUAL_OUT || kind_reg == SFR_RD_DUAL_IO;
  wire [5:0] in_step = dual_in ? 6'h02 : 6'h01;
  wire [3:0] out_step = dual_out ? 4'h2 : 4'h1;
  wire [31:0] addr_full = dual_in ? {addr_sh_reg[29:0], link.lane1, link.lane0}
                                  : {addr_sh_reg[30:0], link.lane0};
  // narrow mode takes its top byte from the extended address byte
  wire [31:0] addr_eff = wide_reg ? addr_full
                                  : {extended_address_byte, addr_full[23:0]};
  wire addr_done = cnt_reg == in_step;
  wire [ADDR_W-1:0] addr_inc = mem_addr == MEM_LAST ? '0 : mem_addr + 1'b1;
  wire byte_start = left_reg == 4'h0;
  wire [7:0] out_src = byte_start ? byte_reg : out_sh_reg;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SFR_ST_CMD;
      kind_reg <= SFR_RD_SINGLE;
      bit_cnt_reg <= 4'h0;
      cmd_sh_reg <= 8'h00;
      cnt_reg <= 6'h00;
      dummy_reg <= 6'h00;
      addr_sh_reg <= 32'h0000_0000;
      read_rejected <= 1'b0;
    end else begin
      read_rejected <= 1'b0;
      if (!link.cs_active) begin
        state_reg <= SFR_ST_CMD;
        bit_cnt_reg <= 4'h0;
      end else if (link.sclk_rise) begin
        case (state_reg)
          SFR_ST_CMD: begin
            cmd_sh_reg <= opcode;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (last_cmd_bit) begin
              // counts address bits; dual-io takes two of them per rising edge
              cnt_reg <= addr_bits;
              kind_reg <= is_read ? SFR_RD_SINGLE : is_fast ? SFR_RD_FAST :
                          is_dout ? SFR_RD_DUAL_OUT : SFR_RD_DUAL_IO;
              dummy_reg <= is_read ? 6'h00 : is_dio ? dummy_dio : dummy_std;
              if (refuse) begin
                state_reg <= SFR_ST_IGNORE;
                read_rejected <= 1'b1;
              end else if (is_any_read) begin
                state_reg <= SFR_ST_ADDR;
              end else if (is_mode) begin
                state_reg <= SFR_ST_HOLD;
              end else begin
                // other instructions, including the 24-bit-only reads, are served elsewhere
                state_reg <= SFR_ST_IGNORE;
              end
            end
          end
          SFR_ST_ADDR: begin
            addr_sh_reg <= addr_full;
            cnt_reg <= cnt_reg - in_step;
            if (addr_done) begin
              cnt_reg <= dummy_reg;
              state_reg <= dummy_reg == 6'h00 ? SFR_ST_DATA : SFR_ST_DUMMY;
            end
          end
          SFR_ST_DUMMY: begin
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              state_reg <= SFR_ST_DATA;
            end
          end
          SFR_ST_DATA: state_reg <= SFR_ST_DATA;
          SFR_ST_HOLD: state_reg <= SFR_ST_HOLD;
          SFR_ST_IGNORE: state_reg <= SFR_ST_IGNORE;
          default: state_reg <= SFR_ST_IGNORE;
        endcase
      end
    end
  end

  // ****************************************
  // address mode, acted on at chip select high
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wide_reg <= `SFR_WIDE_FLAG_RESET;
    end else if (link.cs_rise && state_reg == SFR_ST_HOLD) begin
      wide_reg <= cmd_sh_reg == `SFR_OP_ENTER_WIDE;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wide_address_flag <= `SFR_WIDE_FLAG_RESET;
      config_view <= 8'h00;
    end else begin
      wide_address_flag <= wide_reg;
      config_view <= 8'h00;
      config_view[`SFR_WIDE_FLAG_BIT] <= wide_reg;
      config_view[`SFR_DUMMY_SEL_LSB +: 2] <= dummy_count_select;
    end
  end

  // ****************************************
  // array fetch and data shifter
  // ****************************************
  // fetch starts when the address completes, well before the first fall
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr <= '0;
      mem_rd <= 1'b0;
      fetch_wait_reg <= 1'b0;
      byte_reg <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      fetch_wait_reg <= mem_rd;
      if (fetch_wait_reg) begin
        byte_reg <= mem_rdata;
      end
      if (link.sclk_rise && state_reg == SFR_ST_ADDR && addr_done) begin
        mem_addr <= addr_eff[ADDR_W-1:0];
        mem_rd <= 1'b1;
      end else if (link.sclk_fall && state_reg == SFR_ST_DATA && byte_start) begin
        mem_addr <= addr_inc;
        mem_rd <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_sh_reg <= 8'h00;
      left_reg <= 4'h0;
      io_lane0_out <= 1'b0;
      io_lane1_out <= 1'b0;
      io_lane0_oe <= 1'b0;
      io_lane1_oe <= 1'b0;
    end else if (!link.cs_active || state_reg != SFR_ST_DATA) begin
      left_reg <= 4'h0;
      io_lane0_oe <= 1'b0;
      io_lane1_oe <= 1'b0;
    end else if (link.sclk_fall) begin
      out_sh_reg <= dual_out ? {out_src[5:0], 2'h0} : {out_src[6:0], 1'b0};
      left_reg <= (byte_start ? 4'h8 : left_reg) - out_step;
      io_lane1_out <= out_src[7];
      io_lane1_oe <= 1'b1;
      io_lane0_out <= out_src[6];
      io_lane0_oe <= dual_out;
    end
  end
endmodule

// file: sfr_flash_read_checker.sv
// port assertions for the flash read block
`timescale 1ns/1ps
module sfr_flash_read_checker
  import sfr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic cs_n_pin, // select
  input wire logic sclk_pin, // link clock
  input wire logic write_busy, // busy
  input wire logic io_lane0_oe, // lane 0 drive
  input wire logic io_lane1_out, // lane 1 level
  input wire logic io_lane1_oe, // lane 1 drive
  input wire logic wide_address_flag, // wide mode
  input wire logic [7:0] config_view, // config bits
  input wire logic read_rejected, // refusal
  input wire logic [ADDR_W-1:0] mem_addr, // address
  input wire logic mem_rd // fetch
);
  logic seen_reg;
  logic [ADDR_W-1:0] last_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ********
  // last fetch of this frame
  // ********
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_reg <= 1'h0;
      last_reg <= '0;
    end else if (cs_n_pin) begin
      seen_reg <= 1'h0;
    end else if (mem_rd) begin
      seen_reg <= 1'h1;
      last_reg <= mem_addr;
    end
  end
  a_flag_after_reset: assert property ($rose(reset_n) |-> !wide_address_flag)
    else $error("wide flag set out of reset");
  a_flag_in_view: assert property (wide_address_flag |-> ##[0:1] config_view[5])
    else $error("view misses wide flag");
  a_view_cleared: assert property (!wide_address_flag |-> ##[0:1] !config_view[5])
    else $error("view keeps wide flag");
  a_flag_frame_end: assert property ($changed(wide_address_flag) |-> cs_n_pin && $past(cs_n_pin, 3))
    else $error("wide flag moved inside a frame");
  a_lanes_released: assert property (cs_n_pin [*6] |-> !io_lane1_oe && !io_lane0_oe)
    else $error("lanes driven while deselected");
  a_dual_pair: assert property (io_lane0_oe |-> io_lane1_oe)
    else $error("lane 0 driven alone");
  a_reject_busy: assert property (read_rejected |-> $past(write_busy))
    else $error("refusal without busy");
  a_reject_quiet: assert property (read_rejected |-> (!io_lane1_oe) [*8])
    else $error("refused read drives data");
  a_fetch_in_frame: assert property (mem_rd |-> !$past(cs_n_pin, 4))
    else $error("fetch outside a frame");
  a_addr_step: assert property (mem_rd && seen_reg |-> mem_addr == last_reg + 1'h1)
    else $error("address did not step by one");
  a_data_on_fall: assert property ($changed(io_lane1_out) && io_lane1_oe
    && $past(io_lane1_oe) |-> !sclk_pin && !$past(sclk_pin, 2))
    else $error("data changed away from falling clock");
  c_wide: cover property ($rose(wide_address_flag));
  c_reject: cover property (read_rejected);
  c_dual: cover property ($rose(io_lane0_oe));
endmodule
bind sfr_flash_read sfr_flash_read_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .reset_n,
  .cs_n_pin, .sclk_pin, .write_busy, .io_lane0_oe, .io_lane1_out, .io_lane1_oe,
  .wide_address_flag, .config_view, .read_rejected, .mem_addr, .mem_rd);

// file: sfr_host_model.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic lane0, // resolved lane 0
  input wire logic lane1, // resolved lane 1
  output logic cs_n, // chip select
  output logic sclk, // link clock, idle low
  output logic drv0, // lane 0 level
  output logic drv1 // lane 1 level
);
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    drv0 = 1'h0;
    drv1 = 1'h0;
  end
  task automatic edge2(input logic b1, input logic b0);
    drv1 = b1;
    drv0 = b0;
    #32 sclk = 1'h1;
    #32 sclk = 1'h0;
  endtask
  // unused lanes toggle so a stale level never looks valid
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
      input bit adual, input int nd, input bit ddual, input int nb, output logic [7:0] q [4]);
    int i;
    int k;
    q = '{default: 8'h00};
    cs_n = 1'h0;
    for (i = 7; i >= 0; i--) edge2(~drv1, op[i]);
    k = adual ? 2 : 1;
    for (i = 0; i < na; i += k) edge2(adual ? a[na-1-i] : ~drv1, a[na-k-i]);
    for (i = 0; i < nd; i++) edge2(~drv1, ~drv0);
    k = ddual ? 2 : 1;
    for (i = 0; i < nb * 8; i += k) begin
      drv0 = ~drv0;
      drv1 = ~drv1;
      #32 q[i/8] = ddual ? {q[i/8][5:0], lane1, lane0} : {q[i/8][6:0], lane1};
      sclk = 1'h1;
      #32 sclk = 1'h0;
    end
    #32 cs_n = 1'h1;
    #200;
  endtask
endmodule

// file: sfr_flash_read_bench.sv
// self-checking bench for the flash read block
`timescale 1ns/1ps
`include "sfr_defines.svh"
module sfr_flash_read_bench;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic write_busy = 1'h0;
  logic [1:0] dummy_count_select = 2'h0;
  logic [7:0] extended_address_byte = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic cs_n, sclk, drv0, drv1, lane0, lane1;
  logic io_lane0_out, io_lane0_oe, io_lane1_out, io_lane1_oe, wide_address_flag;
  logic read_rejected, mem_rd;
  logic [7:0] config_view;
  logic [31:0] mem_addr;
  logic [7:0] q [4];
  logic [7:0] rops [4] = '{`SFR_OP_READ, `SFR_OP_FAST_READ, `SFR_OP_DUAL_OUTPUT_READ,
    `SFR_OP_DUAL_IO_READ};
  logic [7:0] ign [3] = '{`SFR_OP_PARAM_TABLE_READ, `SFR_OP_SIGNATURE_READ,
    `SFR_OP_MAKER_DEVICE_ID_READ};
  int n_fail = 0;
  int checks_done = 0;
  bit oe_seen;
  bit rej_seen;
  always #2.5 core_clk = ~core_clk;
  assign lane0 = io_lane0_oe ? io_lane0_out : drv0;
  assign lane1 = io_lane1_oe ? io_lane1_out : drv1;
  always @(negedge core_clk) mem_rdata <= mem_byte(mem_addr);
  always @(posedge core_clk) begin
    oe_seen |= io_lane1_oe;
    rej_seen |= read_rejected;
  end
  sfr_flash_read #(.ADDR_W(32)) u_dut (.core_clk, .reset_n, .cs_n_pin(cs_n), .sclk_pin(sclk),
    .io_lane0_in(lane0), .io_lane1_in(lane1), .io_lane0_out, .io_lane0_oe, .io_lane1_out,
    .io_lane1_oe, .write_busy, .dummy_count_select, .extended_address_byte,
    .wide_address_flag, .config_view, .read_rejected, .mem_addr, .mem_rd, .mem_rdata);
  sfr_host_model u_host (.lane0, .lane1, .cs_n, .sclk, .drv0, .drv1);
  // ********
  // expectations and shared tasks
  // ********
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ {a[12:8], a[31:29]} ^ a[23:16] ^ 8'hA5;
  endfunction
  function automatic int dummies(input logic [7:0] op, input logic [1:0] c);
    if (op == `SFR_OP_READ) return 0;
    if (op == `SFR_OP_DUAL_IO_READ && c == 2'h0) return 4;
    return c == 2'h1 ? 6 : (c == 2'h3 ? 10 : 8);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] a, input int na, input int nb);
    u_host.frame(op, a, na, op == `SFR_OP_DUAL_IO_READ, dummies(op, dummy_count_select),
      op == `SFR_OP_DUAL_IO_READ || op == `SFR_OP_DUAL_OUTPUT_READ, nb, q);
  endtask
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input int na, input int nb);
    int i;
    send(op, a, na, nb);
    for (i = 0; i < nb; i++) check(q[i], mem_byte(a + i));
    check(io_lane1_oe, 1'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
  initial begin
    int c;
    logic [31:0] a;
    void'($urandom(4));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'h1;
    repeat (8) @(negedge core_clk);
    check(wide_address_flag, 1'h0);
    check(config_view, 8'h00);
    $display("test reset done");
    for (c = 0; c < 16; c++) begin
      @(negedge core_clk);
      dummy_count_select = c[3:2];
      extended_address_byte = 8'($urandom);
      a = {extended_address_byte, 24'($urandom)};
      rd(rops[c%4], a, 24, 2);
      check(config_view, {dummy_count_select, 6'h00});
    end
    $display("test narrow reads done");
    u_host.frame(`SFR_OP_ENTER_WIDE, $urandom, 8, 0, 0, 0, 0, q);
    check(wide_address_flag, 1'h1);
    check(config_view[5], 1'h1);
    rd(`SFR_OP_READ, 32'hFFFFFFFF, 32, 3);
    rd(`SFR_OP_DUAL_IO_READ, $urandom, 32, 2);
    for (c = 0; c < 3; c++) begin
      oe_seen = 1'b0;
      u_host.frame(ign[c], $urandom, 24, 0, 8, 0, 1, q);
      check(oe_seen, 1'h0);
    end
    check(wide_address_flag, 1'h1);
    $display("test wide mode done");
    @(negedge core_clk) write_busy = 1'h1;
    for (c = 0; c < 4; c++) begin
      oe_seen = 1'b0;
      rej_seen = 1'b0;
      send(rops[c], $urandom, 32, 1);
      check(rej_seen, c != 0);
      check(oe_seen, c == 0);
    end
    @(negedge core_clk) write_busy = 1'h0;
    $display("test busy refusal done");
    u_host.frame(`SFR_OP_EXIT_WIDE, 32'h0, 0, 0, 0, 0, 0, q);
    check(wide_address_flag, 1'h0);
    check(config_view[5], 1'h0);
    rd(`SFR_OP_FAST_READ, {extended_address_byte, 24'($urandom)}, 24, 2);
    u_host.frame(`SFR_OP_ENTER_WIDE, 32'h0, 0, 0, 0, 0, 0, q);
    @(negedge core_clk) reset_n = 1'h0;
    repeat (4) @(negedge core_clk);
    reset_n = 1'h1;
    repeat (8) @(negedge core_clk);
    check(wide_address_flag, 1'h0);
    rd(`SFR_OP_READ, {extended_address_byte, 24'($urandom)}, 24, 2);
    $display("test exit and reset done");
    complete_run();
  end
endmodule
